/* design/aircs_defines.vh */
// Register offsets, field positions, reset values and codes for the converter input/reference control
`ifndef AIRCS_DEFINES_VH
`define AIRCS_DEFINES_VH
`define AIRCS_OFF_INCLK 4'h0
`define AIRCS_OFF_AMP 4'h4
`define AIRCS_OFF_BGR 4'h8
`define AIRCS_OFF_STATUS 4'hC
`define AIRCS_RST_INCLK 8'h00
`define AIRCS_RST_AMP 8'h00
`define AIRCS_RST_BGR 8'h00
`define AIRCS_MASK_INCLK 8'hF7
`define AIRCS_MASK_AMP 8'h9F
`define AIRCS_MASK_BGR 8'h01
`define AIRCS_SRC_MSB 7
`define AIRCS_SRC_LSB 4
`define AIRCS_DIV_MSB 2
`define AIRCS_DIV_LSB 0
`define AIRCS_AMPEN_BIT 7
`define AIRCS_AMPIN_BIT 4
`define AIRCS_REF_MSB 3
`define AIRCS_REF_LSB 2
`define AIRCS_GAIN_MSB 1
`define AIRCS_GAIN_LSB 0
`define AIRCS_BGEN_BIT 0
`define AIRCS_IN_EXT 3'h0
`define AIRCS_IN_SUP1 3'h1
`define AIRCS_IN_SUP2 3'h2
`define AIRCS_IN_SUP4 3'h3
`define AIRCS_IN_AMP1 3'h4
`define AIRCS_IN_AMP2 3'h5
`define AIRCS_IN_AMP4 3'h6
`define AIRCS_IN_GND 3'h7
`define AIRCS_REF_SUPPLY 2'h0
`define AIRCS_REF_PIN 2'h1
`define AIRCS_REF_AMP 2'h2
`define AIRCS_RESP_OKAY 2'h0
`define AIRCS_RESP_SLVERR 2'h2
`endif

/* design/aircs_prescaler.v */
// Conversion clock prescaler: free-running counter giving a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module aircs_prescaler #(
  parameter CNT_W = 7
) (
  input wire sys_clk,
  input wire rst,
  input wire [2:0] div_sel,
  output reg conv_clk_en_q
);
  reg [CNT_W-1:0] cnt_q; // Free-running divide counter
  reg [CNT_W-1:0] mask_d; // Low bits that must be all ones for a tick

  // Ratio 2^div_sel: tick when the low div_sel bits are all ones
  always @*
  begin
    mask_d = {CNT_W{1'b1}} >> (CNT_W - div_sel);
  end

  // Counter never stops, so a new ratio takes effect on the next aligned wrap
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= {CNT_W{1'b0}};
      conv_clk_en_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      conv_clk_en_q <= ((cnt_q & mask_d) == mask_d);
    end
  end
endmodule
`default_nettype wire

/* design/aircs_top.v */
// Converter input source, clock prescaler and reference amplifier control with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "aircs_defines.vh"
module aircs_top #(
  parameter ADDR_W = 4
) (
  input wire sys_clk,
  input wire rst,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // External channel number from the channel-select register elsewhere
  input wire [3:0] external_channel_sel,
  // Analog switch controls
  output reg ext_channel_connect_q,
  output reg [3:0] ext_channel_num_q,
  output reg supply_in_full_q,
  output reg supply_in_half_q,
  output reg supply_in_quarter_q,
  output reg amp_in_full_q,
  output reg amp_in_half_q,
  output reg amp_in_quarter_q,
  output reg ground_in_q,
  output reg conv_clk_en_q,
  output reg ref_amp_enable_q,
  output reg ref_amp_pin_connect_q,
  output reg ref_amp_bandgap_connect_q,
  output reg [3:0] ref_amp_gain_onehot_q,
  output reg ref_supply_connect_q,
  output reg ref_pin_connect_q,
  output reg ref_amp_out_connect_q,
  output reg bandgap_enable_q
);
  // Stored registers, implemented bits only
  reg [7:0] inclk_q; // Input source and clock select
  reg [7:0] amp_q; // Reference amplifier control
  reg [7:0] bgr_q; // Bandgap control
  // Write channel capture
  reg aw_held_q; // Write address taken, waiting for data
  reg [ADDR_W-1:0] aw_addr_q;
  reg w_held_q; // Write data taken, waiting for address
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write; // Both halves present, response slot free
  wire prescale_tick; // One-cycle tick from the prescaler
  reg [2:0] in_code_d; // Decoded input class
  reg [31:0] rd_word_d; // Read mux

  // Decode the four-bit source field into an input class
  function [2:0] decode_source;
    input [3:0] src;
    begin
      case (src)
        4'h1: decode_source = `AIRCS_IN_SUP1;
        4'h2: decode_source = `AIRCS_IN_SUP2;
        4'h3: decode_source = `AIRCS_IN_SUP4;
        4'h5: decode_source = `AIRCS_IN_AMP1;
        4'h6: decode_source = `AIRCS_IN_AMP2;
        4'h7: decode_source = `AIRCS_IN_AMP4;
        4'h8, 4'h9, 4'hA, 4'hB: decode_source = `AIRCS_IN_GND;
        default: decode_source = `AIRCS_IN_EXT;
      endcase
    end
  endfunction

  // Decode the two-bit reference field; either 1x code selects the amplifier
  function [1:0] decode_ref;
    input [1:0] sel;
    begin
      if (sel[1])
        decode_ref = `AIRCS_REF_AMP;
      else
        decode_ref = sel;
    end
  endfunction

  // Merge one byte lane into a register, keeping unimplemented bits zero
  function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] data;
    input strb;
    input [7:0] mask;
    begin
      if (strb)
        merge_byte = data & mask;
      else
        merge_byte = old;
    end
  endfunction

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  // Write path: address and data are taken independently, in either order
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AIRCS_RESP_OKAY;
    end
    else
    begin
      // Ready is a one-cycle pulse so each valid is taken exactly once
      s_axi_awready <= s_axi_awvalid && !aw_held_q && !s_axi_awready;
      s_axi_wready <= s_axi_wvalid && !w_held_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped address answers SLVERR and stores nothing
        if (aw_addr_q[ADDR_W-1:2] <= 2'h2 && aw_addr_q[1:0] == 2'h0)
          s_axi_bresp <= `AIRCS_RESP_OKAY;
        else
          s_axi_bresp <= `AIRCS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register storage; all implemented fields come up at zero
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      inclk_q <= `AIRCS_RST_INCLK;
      amp_q <= `AIRCS_RST_AMP;
      bgr_q <= `AIRCS_RST_BGR;
    end
    else if (do_write)
    begin
      case (aw_addr_q)
        `AIRCS_OFF_INCLK: inclk_q <= merge_byte(inclk_q, w_data_q[7:0], w_strb_q[0],
          `AIRCS_MASK_INCLK);
        `AIRCS_OFF_AMP: amp_q <= merge_byte(amp_q, w_data_q[7:0], w_strb_q[0],
          `AIRCS_MASK_AMP);
        `AIRCS_OFF_BGR: bgr_q <= merge_byte(bgr_q, w_data_q[7:0], w_strb_q[0],
          `AIRCS_MASK_BGR);
        default: inclk_q <= inclk_q;
      endcase
    end
  end

  // Read mux; status word mirrors the live switch state for software
  always @*
  begin
    case (s_axi_araddr)
      `AIRCS_OFF_INCLK: rd_word_d = {24'h000000, inclk_q};
      `AIRCS_OFF_AMP: rd_word_d = {24'h000000, amp_q};
      `AIRCS_OFF_BGR: rd_word_d = {24'h000000, bgr_q};
      `AIRCS_OFF_STATUS: rd_word_d = {24'h000000, ext_channel_connect_q, ground_in_q,
        ref_amp_enable_q, bandgap_enable_q, ref_pin_connect_q, ref_amp_pin_connect_q,
        ref_amp_out_connect_q, conv_clk_en_q};
      default: rd_word_d = 32'h00000000;
    endcase
  end

  // Read path: one read at a time, data answered the cycle after the address
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AIRCS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word_d;
        if (s_axi_araddr[1:0] == 2'h0)
          s_axi_rresp <= `AIRCS_RESP_OKAY;
        else
          s_axi_rresp <= `AIRCS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Conversion clock enable from the divider
  aircs_prescaler #(
    .CNT_W(7)
  ) u_prescaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .div_sel(inclk_q[`AIRCS_DIV_MSB:`AIRCS_DIV_LSB]),
    .conv_clk_en_q(prescale_tick)
  );

  always @*
  begin
    in_code_d = decode_source(inclk_q[`AIRCS_SRC_MSB:`AIRCS_SRC_LSB]);
  end

  // Analog switch drive; registered so no decode glitch reaches a switch
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_channel_connect_q <= 1'b0;
      ext_channel_num_q <= 4'h0;
      supply_in_full_q <= 1'b0;
      supply_in_half_q <= 1'b0;
      supply_in_quarter_q <= 1'b0;
      amp_in_full_q <= 1'b0;
      amp_in_half_q <= 1'b0;
      amp_in_quarter_q <= 1'b0;
      ground_in_q <= 1'b0;
      conv_clk_en_q <= 1'b0;
      ref_amp_enable_q <= 1'b0;
      ref_amp_pin_connect_q <= 1'b0;
      ref_amp_bandgap_connect_q <= 1'b0;
      ref_amp_gain_onehot_q <= 4'h0;
      ref_supply_connect_q <= 1'b0;
      ref_pin_connect_q <= 1'b0;
      ref_amp_out_connect_q <= 1'b0;
      bandgap_enable_q <= 1'b0;
    end
    else
    begin
      // Only one input switch can close at a time
      ext_channel_connect_q <= (in_code_d == `AIRCS_IN_EXT);
      // Channel number is forced to zero when external path is off
      ext_channel_num_q <= (in_code_d == `AIRCS_IN_EXT) ? external_channel_sel : 4'h0;
      supply_in_full_q <= (in_code_d == `AIRCS_IN_SUP1);
      supply_in_half_q <= (in_code_d == `AIRCS_IN_SUP2);
      supply_in_quarter_q <= (in_code_d == `AIRCS_IN_SUP4);
      amp_in_full_q <= (in_code_d == `AIRCS_IN_AMP1);
      amp_in_half_q <= (in_code_d == `AIRCS_IN_AMP2);
      amp_in_quarter_q <= (in_code_d == `AIRCS_IN_AMP4);
      ground_in_q <= (in_code_d == `AIRCS_IN_GND);
      conv_clk_en_q <= prescale_tick;
      // Amplifier power follows the bit alone; software keeps it on when used
      ref_amp_enable_q <= amp_q[`AIRCS_AMPEN_BIT];
      ref_amp_pin_connect_q <= !amp_q[`AIRCS_AMPIN_BIT];
      ref_amp_bandgap_connect_q <= amp_q[`AIRCS_AMPIN_BIT];
      // Gain 1, 1.667, 2.5, 3.333 as one-hot trim selects
      ref_amp_gain_onehot_q <= 4'h1 << amp_q[`AIRCS_GAIN_MSB:`AIRCS_GAIN_LSB];
      ref_supply_connect_q <= (decode_ref(amp_q[`AIRCS_REF_MSB:`AIRCS_REF_LSB])
        == `AIRCS_REF_SUPPLY);
      ref_pin_connect_q <= (decode_ref(amp_q[`AIRCS_REF_MSB:`AIRCS_REF_LSB])
        == `AIRCS_REF_PIN);
      ref_amp_out_connect_q <= (decode_ref(amp_q[`AIRCS_REF_MSB:`AIRCS_REF_LSB])
        == `AIRCS_REF_AMP);
      bandgap_enable_q <= bgr_q[`AIRCS_BGEN_BIT];
    end
  end
endmodule
`default_nettype wire

/* tb/aircs_sva.sv */
// Checker for switch decode, prescaler spacing and bus answers of aircs_top
`timescale 1ns/1ps
`default_nettype none
module aircs_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0] external_channel_sel,
  input wire logic ext_channel_connect_q,
  input wire logic [3:0] ext_channel_num_q,
  input wire logic supply_in_full_q,
  input wire logic supply_in_half_q,
  input wire logic supply_in_quarter_q,
  input wire logic amp_in_full_q,
  input wire logic amp_in_half_q,
  input wire logic amp_in_quarter_q,
  input wire logic ground_in_q,
  input wire logic conv_clk_en_q,
  input wire logic ref_amp_pin_connect_q,
  input wire logic ref_amp_bandgap_connect_q,
  input wire logic [3:0] ref_amp_gain_onehot_q,
  input wire logic ref_supply_connect_q,
  input wire logic ref_pin_connect_q,
  input wire logic ref_amp_out_connect_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Cycles since the last clock enable; a gap above 128 means a lost ratio
  logic [7:0] gap_q;
  // Counter restarts at each enable pulse
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      gap_q <= 8'h00;
    else if (conv_clk_en_q)
      gap_q <= 8'h00;
    else
      gap_q <= gap_q + 8'h01;
  end
  // Outputs hold reset zeros for one edge after release, so skip that sample
  a_src_onehot: assert property (!$past(rst) |-> $onehot({ext_channel_connect_q,
    supply_in_full_q, supply_in_half_q, supply_in_quarter_q, amp_in_full_q,
    amp_in_half_q, amp_in_quarter_q, ground_in_q})) else $error("input source not one-hot");
  a_ext_isolate: assert property (!ext_channel_connect_q |-> ext_channel_num_q == 4'h0)
    else $error("channel number leaks while disconnected");
  a_ext_number: assert property (ext_channel_connect_q && !$past(rst) |->
    ext_channel_num_q == $past(external_channel_sel)) else $error("channel number wrong");
  a_gain_onehot: assert property (!$past(rst) |-> $onehot(ref_amp_gain_onehot_q))
    else $error("gain select not one-hot");
  a_ref_onehot: assert property (!$past(rst) |-> $onehot({ref_supply_connect_q,
    ref_pin_connect_q, ref_amp_out_connect_q})) else $error("reference path not one-hot");
  a_amp_input: assert property (!$past(rst) |->
    (ref_amp_pin_connect_q ^ ref_amp_bandgap_connect_q)) else $error("amplifier input clash");
  a_clk_gap: assert property (gap_q <= 8'h80) else $error("clock enable gap too long");
  a_rdata_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  cover property (ground_in_q);
  cover property (amp_in_quarter_q && ref_amp_bandgap_connect_q);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind aircs_top aircs_sva u_sva (.sys_clk, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rdata, .external_channel_sel, .ext_channel_connect_q,
  .ext_channel_num_q, .supply_in_full_q, .supply_in_half_q, .supply_in_quarter_q,
  .amp_in_full_q, .amp_in_half_q, .amp_in_quarter_q, .ground_in_q, .conv_clk_en_q,
  .ref_amp_pin_connect_q, .ref_amp_bandgap_connect_q, .ref_amp_gain_onehot_q,
  .ref_supply_connect_q, .ref_pin_connect_q, .ref_amp_out_connect_q);
`default_nettype wire

/* tb/adc_input_ref_select_ctrl_bench.sv */
// Self-checking bench for the converter input and reference control block
`timescale 1ns/1ps
`default_nettype none
`include "aircs_defines.vh"
module adc_input_ref_select_ctrl_bench;
  logic sys_clk = 1'h0, rst = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [3:0] external_channel_sel = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire ext_channel_connect_q, supply_in_full_q, supply_in_half_q, supply_in_quarter_q;
  wire amp_in_full_q, amp_in_half_q, amp_in_quarter_q, ground_in_q, conv_clk_en_q;
  wire ref_amp_enable_q, ref_amp_pin_connect_q, ref_amp_bandgap_connect_q, bandgap_enable_q;
  wire ref_supply_connect_q, ref_pin_connect_q, ref_amp_out_connect_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] ext_channel_num_q, ref_amp_gain_onehot_q;
  int error_cnt = 0, tests_run = 0, n, k;
  // Amplifier rows: written byte, then {enable, pin, bandgap, gain one-hot, reference path}
  // Rows met by amplifier source codes keep the amplifier powered; row 0 never is
  localparam logic [17:0] amp_rows [4] = '{{8'h60, 10'h10C}, {8'h95, 10'h292},
    {8'h9A, 10'h2A1}, {8'h8F, 10'h341}};
  // Bandgap start-up allowance in cycles; value of our own choosing
  localparam int BG_SETTLE = 16;
  aircs_top u_dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_channel_sel, .ext_channel_connect_q, .ext_channel_num_q, .supply_in_full_q,
    .supply_in_half_q, .supply_in_quarter_q, .amp_in_full_q, .amp_in_half_q,
    .amp_in_quarter_q, .ground_in_q, .conv_clk_en_q, .ref_amp_enable_q,
    .ref_amp_pin_connect_q, .ref_amp_bandgap_connect_q, .ref_amp_gain_onehot_q,
    .ref_supply_connect_q, .ref_pin_connect_q, .ref_amp_out_connect_q, .bandgap_enable_q);
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  // Input source switch vector expected for a source code
  function automatic logic [7:0] exp_src(input logic [3:0] c);
    case (c)
      4'h1: return 8'h40;
      4'h2: return 8'h20;
      4'h3: return 8'h10;
      4'h5: return 8'h08;
      4'h6: return 8'h04;
      4'h7: return 8'h02;
      default: return (c[3:2] == 2'h2) ? 8'h01 : 8'h80;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A wait that ran out ends the run
  task automatic tmo;
    if (n >= 60)
    begin
      error_cnt++;
      results();
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 60);
    tmo();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  // Read one register and compare its word
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 60);
    tmo();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(nm, rd, e);
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rchk("inclk reset", `AIRCS_OFF_INCLK, 32'h0);
    rchk("amp reset", `AIRCS_OFF_AMP, 32'h0);
    rchk("bgr reset", `AIRCS_OFF_BGR, 32'h0);
    chk("src reset", {ext_channel_connect_q, supply_in_full_q, supply_in_half_q,
      supply_in_quarter_q, amp_in_full_q, amp_in_half_q, amp_in_quarter_q, ground_in_q},
      8'h80);
    chk("amp reset out", {ref_amp_enable_q, ref_amp_pin_connect_q, ref_amp_bandgap_connect_q,
      ref_amp_gain_onehot_q, ref_supply_connect_q, ref_pin_connect_q, ref_amp_out_connect_q,
      bandgap_enable_q}, 11'h218);
    // Bandgap up and settled before any row picks it as amplifier input
    wr(`AIRCS_OFF_BGR, 32'h1, 4'h1);
    repeat (BG_SETTLE) @(posedge sys_clk);
    // Every source code, with the amplifier rows cycled beside them
    for (int i = 0; i < 16; i++)
    begin
      external_channel_sel <= i[3:0] ^ 4'h5;
      wr(`AIRCS_OFF_INCLK, {24'hFFFFFF, i[3:0], 4'hF}, 4'hF);
      wr(`AIRCS_OFF_AMP, {24'hFFFFFF, amp_rows[i % 4][17:10]}, 4'hF);
      repeat (2) @(posedge sys_clk);
      chk("source", {ext_channel_connect_q, supply_in_full_q, supply_in_half_q,
        supply_in_quarter_q, amp_in_full_q, amp_in_half_q, amp_in_quarter_q, ground_in_q},
        exp_src(i[3:0]));
      chk("channel", ext_channel_num_q, exp_src(i[3:0]) > 8'h7F ? i[3:0] ^ 4'h5 : 4'h0);
      chk("amp out", {ref_amp_enable_q, ref_amp_pin_connect_q, ref_amp_bandgap_connect_q,
        ref_amp_gain_onehot_q, ref_supply_connect_q, ref_pin_connect_q, ref_amp_out_connect_q},
        amp_rows[i % 4][9:0]);
      rchk("inclk", `AIRCS_OFF_INCLK, {i[3:0], 4'h7});
      rchk("amp", `AIRCS_OFF_AMP, amp_rows[i % 4][17:10] & `AIRCS_MASK_AMP);
    end
    // Spacing between enable pulses for every divider code
    for (int d = 0; d < 8; d++)
    begin
      wr(`AIRCS_OFF_INCLK, d, 4'hF);
      // Let a pulse decided under the old ratio drain out of the pipeline
      repeat (2) @(posedge sys_clk);
      k = 0;
      do @(posedge sys_clk); while (!conv_clk_en_q && ++k < 300);
      k = 0;
      do @(posedge sys_clk); while (!conv_clk_en_q && ++k < 300);
      chk("divide", k + 1, 1 << d);
    end
    wr(`AIRCS_OFF_BGR, 32'hFFFFFFFF, 4'hF);
    repeat (2) @(posedge sys_clk);
    chk("bandgap on", bandgap_enable_q, 1'h1);
    rchk("bgr", `AIRCS_OFF_BGR, 32'h1);
    wr(`AIRCS_OFF_BGR, 32'h0, 4'h1);
    repeat (2) @(posedge sys_clk);
    chk("bandgap off", bandgap_enable_q, 1'h0);
    // Refused and masked writes leave registers alone
    wr(4'h6, 32'hFF, 4'hF);
    chk("unaligned resp", rsp, `AIRCS_RESP_SLVERR);
    wr(`AIRCS_OFF_BGR, 32'hFF, 4'h0);
    rchk("no strobe", `AIRCS_OFF_BGR, 32'h0);
    // Reset in mid-run clears what was written
    wr(`AIRCS_OFF_INCLK, 32'hF7, 4'hF);
    rchk("inclk before reset", `AIRCS_OFF_INCLK, 32'hF7);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rchk("inclk rereset", `AIRCS_OFF_INCLK, 32'h0);
    // Status after reset: external path, amplifier pin input, enable every cycle
    rchk("status", `AIRCS_OFF_STATUS, 32'h85);
    chk("status resp", rsp, `AIRCS_RESP_OKAY);
    rchk("odd read", 4'h2, 32'h0);
    chk("odd read resp", rsp, `AIRCS_RESP_SLVERR);
    results();
  end
endmodule
`default_nettype wire
